// ===== logic/spi_master_fifo_cs_timing.sv
// spi master data ports, byte queues and select timing behind an ahb-lite slave
// assumes one clock hclk at 100 MHz, asynchronous active-low reset, zero-wait single-word master
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps

`include "spi_timing_defines.svh"

module spi_master_fifo_cs_timing
    import spi_timing_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // interrupt
    output logic             irq,
    // spi link
    output logic             sclk,
    output logic             cs_n,
    output logic             io0_out,
    input  wire logic        io1_in,
    // third io line, write-protect
    input  wire logic        io2_in,
    output logic             io2_out,
    output logic             io2_oe_n,
    // fourth io line, pause
    input  wire logic        io3_in,
    output logic             io3_out,
    output logic             io3_oe_n
);

    state_s r;
    state_s n;

    logic [2:0] wr_nb;
    logic [2:0] rd_nb;
    logic [7:0] half_eff;
    logic       load_byte;
    logic       push_rx;
    logic       ev_done;
    logic       ev_txerr;
    logic       ev_rxerr;
    logic [7:0] a_addr;

    // r holds every flip-flop of the block and n its next value; both are
    // built in one pass so that a bus access and an engine event in the same
    // cycle work on the same queue pointers and counts, the engine after the bus
    always_comb begin
        n         = r;
        load_byte = 1'b0;
        push_rx   = 1'b0;
        ev_done   = 1'b0;
        ev_txerr  = 1'b0;
        ev_rxerr  = 1'b0;
        a_addr    = haddr[7:0];
        half_eff  = (r.half_div == 8'h00) ? 8'h01 : r.half_div;

        // bytes added by the write in its data phase and taken by the read in
        // its address phase; sizes above a word count as a word
        case (r.ph_size)
            3'h0:    wr_nb = 3'h1;
            3'h1:    wr_nb = 3'h2;
            default: wr_nb = 3'h4;
        endcase
        case (hsize)
            3'h0:    rd_nb = 3'h1;
            3'h1:    rd_nb = 3'h2;
            default: rd_nb = 3'h4;
        endcase

        // pin synchronisers
        // only the second stage of each pair is read by the engine or the bus
        n.miso_s1 = io1_in;
        n.miso_s2 = r.miso_s1;
        n.io2_s1  = io2_in;
        n.io2_s2  = r.io2_s1;
        n.io3_s1  = io3_in;
        n.io3_s2  = r.io3_s1;

        // free-running delay counters
        // they only count down; the engine reloads them when select rises
        if (r.gap != 8'h00) begin
            n.gap = r.gap - 8'h01;
        end
        if (r.hold != 4'h0) begin
            n.hold = r.hold - 4'h1;
        end

        // write data phase
        if (r.ph_valid && r.ph_write) begin
            case (r.ph_addr)
                `TX_PORT_OFF: begin
                    // all or none: a write that does not fit stores no byte at all
                    if (({1'b0, r.tx_cnt} + {3'h0, wr_nb}) > `FIFO_DEPTH) begin
                        ev_txerr = 1'b1;
                    end else begin
                        for (int i = 0; i < 4; i++) begin
                            if (i < int'(wr_nb)) begin
                                n.txq[n.tx_wr] = hwdata[8*i +: 8];
                                n.tx_wr        = n.tx_wr + 4'h1;
                            end
                        end
                        n.tx_cnt = r.tx_cnt + {2'h0, wr_nb};
                    end
                end
                `CTRL_OFF: begin
                    n.wp_hold_en = hwdata[`CTRL_WPHOLD_BIT];
                    n.xfer_len   = hwdata[`CTRL_LEN_LSB +: 8];
                    n.half_div   = hwdata[`CTRL_DIV_LSB +: 8];
                    if (hwdata[`CTRL_START_BIT]) begin
                        n.start_pend = 1'b1;
                    end
                end
                `STATUS_OFF: begin
                    // write one to clear; events of this cycle are or-ed back in below
                    n.status = r.status & ~hwdata[2:0];
                end
                `MASK_OFF: begin
                    n.mask = hwdata[2:0];
                end
                `TIMING_OFF: begin
                    // reserved bits are not stored and read back as zero
                    n.idle_dly = hwdata[`IDLE_DLY_LSB +: 8];
                    n.hold_dly = hwdata[`HOLD_DLY_LSB +: 4];
                    n.end_dly  = hwdata[`END_DLY_LSB +: 4];
                    n.lead_dly = hwdata[`LEAD_DLY_LSB +: 4];
                end
                default: begin
                end
            endcase
        end

        // address phase; read data registered for the following data phase
        // read side effects, the receive pop and its error, happen at this edge
        n.ph_valid = hsel && htrans[1] && hready;
        n.ph_write = hwrite;
        n.ph_addr  = a_addr;
        n.ph_size  = hsize;
        n.hrdata   = 32'h0000_0000;
        if (hsel && htrans[1] && hready && !hwrite) begin
            case (a_addr)
                `RX_PORT_OFF: begin
                    // an underflow still hands over the bytes held, upper lanes zero
                    if ({2'h0, rd_nb} > r.rx_cnt) begin
                        ev_rxerr = 1'b1;
                    end
                    for (int i = 0; i < 4; i++) begin
                        if (i < int'(rd_nb) && n.rx_cnt != 5'h00) begin
                            n.hrdata[8*i +: 8] = n.rxq[n.rx_rd];
                            n.rx_rd            = n.rx_rd + 4'h1;
                            n.rx_cnt           = n.rx_cnt - 5'h01;
                        end
                    end
                end
                `CTRL_OFF: begin
                    n.hrdata[`CTRL_WPHOLD_BIT]    = r.wp_hold_en;
                    n.hrdata[`CTRL_LEN_LSB +: 8]  = r.xfer_len;
                    n.hrdata[`CTRL_DIV_LSB +: 8]  = r.half_div;
                end
                `STATUS_OFF: begin
                    n.hrdata[2:0]          = r.status;
                    n.hrdata[`ST_BUSY_BIT] = (r.st != ST_IDLE) || r.start_pend;
                    n.hrdata[`ST_IO2_BIT]  = r.io2_s2;
                    n.hrdata[`ST_IO3_BIT]  = r.io3_s2;
                end
                `MASK_OFF: begin
                    n.hrdata[2:0] = r.mask;
                end
                `COUNT_OFF: begin
                    // receive count in the upper half, transmit count in the lower
                    n.hrdata = {11'h000, r.rx_cnt, 11'h000, r.tx_cnt};
                end
                `TIMING_OFF: begin
                    n.hrdata[`IDLE_DLY_LSB +: 8] = r.idle_dly;
                    n.hrdata[`HOLD_DLY_LSB +: 4] = r.hold_dly;
                    n.hrdata[`END_DLY_LSB +: 4]  = r.end_dly;
                    n.hrdata[`LEAD_DLY_LSB +: 4] = r.lead_dly;
                end
                default: begin
                end
            endcase
        end

        // transfer engine
        // idle -> lead (select low) -> setup (extra half period) -> shift -> trail
        // lead, end and idle waits each last their loaded value plus one cycle
        case (r.st)
            ST_IDLE: begin
                // a start waits for the idle gap; zero length only reports done
                if (r.start_pend && r.gap == 8'h00) begin
                    n.start_pend = 1'b0;
                    if (r.xfer_len == 8'h00) begin
                        ev_done = 1'b1;
                    end else begin
                        n.cs_n       = 1'b0;
                        n.cnt        = {4'h0, r.lead_dly};
                        n.bytes_left = r.xfer_len;
                        n.bit_idx    = 3'h0;
                        n.sclk       = 1'b0;
                        load_byte    = 1'b1;
                        n.st         = ST_LEAD;
                    end
                end
            end
            ST_LEAD: begin
                // select is low; io0 already shows the first bit
                if (r.cnt != 8'h00) begin
                    n.cnt = r.cnt - 8'h01;
                end else begin
                    n.cnt = half_eff - 8'h01;
                    n.st  = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // the extra half period lets io0 settle ahead of the first rise
                if (r.cnt != 8'h00) begin
                    n.cnt = r.cnt - 8'h01;
                end else begin
                    n.cnt = half_eff - 8'h01;
                    n.st  = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                // each level lasts one half period; rise samples io1, fall shifts io0
                // the eighth fall closes a byte and loads the next or enters the trail
                if (r.cnt != 8'h00) begin
                    n.cnt = r.cnt - 8'h01;
                end else begin
                    n.cnt  = half_eff - 8'h01;
                    n.sclk = ~r.sclk;
                    if (!r.sclk) begin
                        n.sh_rx = {r.sh_rx[6:0], r.miso_s2};
                    end else if (r.bit_idx == 3'h7) begin
                        push_rx   = 1'b1;
                        n.bit_idx = 3'h0;
                        if (r.bytes_left == 8'h01) begin
                            n.cnt = {4'h0, r.end_dly};
                            n.st  = ST_TRAIL;
                        end else begin
                            n.bytes_left = r.bytes_left - 8'h01;
                            load_byte    = 1'b1;
                        end
                    end else begin
                        n.sh_tx   = {r.sh_tx[6:0], 1'b0};
                        n.bit_idx = r.bit_idx + 3'h1;
                    end
                end
            end
            ST_TRAIL: begin
                // done is flagged at deselect; the idle gap only holds the next start
                if (r.cnt != 8'h00) begin
                    n.cnt = r.cnt - 8'h01;
                end else begin
                    n.cs_n  = 1'b1;
                    n.gap   = r.idle_dly;
                    n.hold  = r.hold_dly;
                    ev_done = 1'b1;
                    n.st    = ST_IDLE;
                end
            end
            default: begin
                // an unused state code falls back to idle with select released
                n.st   = ST_IDLE;
                n.cs_n = 1'b1;
                n.sclk = 1'b0;
            end
        endcase

        // received byte into the queue; a full queue drops it and flags an error
        // it runs after the bus pop so a same-cycle read frees room first
        if (push_rx) begin
            if (n.rx_cnt == 5'h10) begin
                ev_rxerr = 1'b1;
            end else begin
                n.rxq[n.rx_wr] = n.sh_rx;
                n.rx_wr        = n.rx_wr + 4'h1;
                n.rx_cnt       = n.rx_cnt + 5'h01;
            end
        end

        // next outgoing byte; an empty queue sends zeros
        // it runs after the bus push so a byte written this cycle can go out
        if (load_byte) begin
            if (n.tx_cnt != 5'h00) begin
                n.sh_tx  = n.txq[n.tx_rd];
                n.tx_rd  = n.tx_rd + 4'h1;
                n.tx_cnt = n.tx_cnt - 5'h01;
            end else begin
                n.sh_tx = 8'h00;
            end
        end

        // sticky events, set wins over a same-cycle clear
        n.status = n.status | {ev_rxerr, ev_txerr, ev_done};

        // lines three and four are driven only when idle and the hold delay has run out
        n.io_drive = n.wp_hold_en && n.cs_n && (n.hold == 4'h0);
    end

    // the reset branch loads the field defaults, the rest is zero
    // (idle state, select high, lines three and four released)
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r            <= '0;
            r.st         <= ST_IDLE;
            r.cs_n       <= 1'b1;
            r.half_div   <= `DIV_RST;
            r.idle_dly   <= `IDLE_DLY_RST;
            r.hold_dly   <= `HOLD_DLY_RST;
            r.end_dly    <= `END_DLY_RST;
            r.lead_dly   <= `LEAD_DLY_RST;
        end else begin
            r <= n;
        end
    end

    // zero wait states and an always okay response
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = r.hrdata;
    assign irq       = |(r.status & r.mask);

    assign sclk      = r.sclk;
    assign cs_n      = r.cs_n;
    assign io0_out   = r.sh_tx[7];

    // lines three and four only ever drive their inactive high level
    assign io2_out   = 1'b1;
    assign io3_out   = 1'b1;
    assign io2_oe_n  = ~r.io_drive;
    assign io3_oe_n  = ~r.io_drive;

endmodule

// ===== logic/spi_timing_defines.svh
// register offsets, field positions, reset values and sizes of the spi data-port and select-timing block
// assumes a 32-bit ahb-lite slave decoding haddr[7:0]
`ifndef SPI_TIMING_DEFINES_SVH
`define SPI_TIMING_DEFINES_SVH

`define CTRL_OFF        8'h00
`define STATUS_OFF      8'h04
`define MASK_OFF        8'h08
`define COUNT_OFF       8'h14
`define TX_PORT_OFF     8'h20
`define RX_PORT_OFF     8'h24
`define TIMING_OFF      8'h28

`define CTRL_START_BIT  0
`define CTRL_WPHOLD_BIT 1
`define CTRL_LEN_LSB    8
`define CTRL_DIV_LSB    16
`define DIV_RST         8'h02

`define ST_DONE_BIT     0
`define ST_TXERR_BIT    1
`define ST_RXERR_BIT    2
`define ST_BUSY_BIT     8
`define ST_IO2_BIT      9
`define ST_IO3_BIT      10

`define IDLE_DLY_LSB    24
`define HOLD_DLY_LSB    16
`define END_DLY_LSB     8
`define LEAD_DLY_LSB    0
`define IDLE_DLY_RST    8'h06
`define HOLD_DLY_RST    4'h6
`define END_DLY_RST     4'h4
`define LEAD_DLY_RST    4'h6

`define FIFO_DEPTH      6'h10

`endif

// ===== logic/spi_timing_pkg.sv
// types of the spi data-port and select-timing block
// assumes spi_timing_defines.svh sits on the include path
`include "spi_timing_defines.svh"

package spi_timing_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LEAD,
        ST_SETUP,
        ST_SHIFT,
        ST_TRAIL
    } spi_state_e;

    typedef logic [15:0][7:0] queue_t;

    typedef struct packed {
        spi_state_e  st;
        queue_t      txq;
        logic [3:0]  tx_rd;
        logic [3:0]  tx_wr;
        logic [4:0]  tx_cnt;
        queue_t      rxq;
        logic [3:0]  rx_rd;
        logic [3:0]  rx_wr;
        logic [4:0]  rx_cnt;
        logic        start_pend;
        logic        wp_hold_en;
        logic [7:0]  xfer_len;
        logic [7:0]  half_div;
        logic [7:0]  idle_dly;
        logic [3:0]  hold_dly;
        logic [3:0]  end_dly;
        logic [3:0]  lead_dly;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic [7:0]  cnt;
        logic [7:0]  gap;
        logic [3:0]  hold;
        logic [7:0]  bytes_left;
        logic [2:0]  bit_idx;
        logic [7:0]  sh_tx;
        logic [7:0]  sh_rx;
        logic        sclk;
        logic        cs_n;
        logic        io_drive;
        logic        ph_valid;
        logic        ph_write;
        logic [7:0]  ph_addr;
        logic [2:0]  ph_size;
        logic [31:0] hrdata;
        logic        miso_s1;
        logic        miso_s2;
        logic        io2_s1;
        logic        io2_s2;
        logic        io3_s1;
        logic        io3_s2;
    } state_s;

endpackage

// ===== verif/spi_slave_model.sv
// mode 0 spi slave: answers 0xa5 first, then echoes the byte it last received
// assumes sclk idles low; miso is not held when deselected
`timescale 1ns/100ps
module spi_slave_model (
    // link
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic mosi,
    output logic      miso
);
    logic [7:0] rx_sh, tx_sh, last, got [0:31];
    logic [2:0] bit_n;
    int         n_got;
    initial begin
        miso  = 1'b0;
        last  = 8'ha5;
        n_got = 0;
    end
    always @(negedge cs_n) begin
        tx_sh = last;
        bit_n = 3'h0;
        miso  = tx_sh[7];
    end
    always @(posedge sclk) if (!cs_n) begin
        rx_sh = {rx_sh[6:0], mosi};
        bit_n = bit_n + 3'h1;
        if (bit_n == 3'h0) begin
            got[n_got] = rx_sh;
            n_got      = n_got + 1;
            last       = rx_sh;
            tx_sh      = rx_sh;
        end
    end
    always @(negedge sclk) if (!cs_n) miso = tx_sh[3'h7 - bit_n];
    // released line shows the inverse of its last value
    always @(posedge cs_n) miso = ~miso;
endmodule

// ===== verif/spi_timing_chk.sv
// checker of select, clock and io-line timing at the ports of the spi block
// assumes a bind to spi_master_fifo_cs_timing; it shadows ctrl, mask and timing writes
`timescale 1ns/100ps
module spi_timing_chk (
    // clock, reset and bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    // watched outputs
    input wire logic        irq,
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic        io2_oe_n,
    input wire logic        io3_oe_n
);
    logic        ap, aw, wp, fst, sd;
    logic [7:0]  aa, hd, g, c, f;
    logic [31:0] tm;
    logic [2:0]  mk;
    wire  [7:0]  h = (hd == 8'h00) ? 8'h01 : hd;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {ap, aw, wp, fst, sd, aa, c, f, mk} <= '0;
            hd <= 8'h02;
            g  <= 8'hff;
            tm <= 32'h06060406;
        end else begin
            ap <= hsel && htrans[1] && hready;
            aw <= hwrite;
            aa <= haddr[7:0];
            if (ap && aw && aa == 8'h28) tm <= hwdata;
            if (ap && aw && aa == 8'h08) mk <= hwdata[2:0];
            if (ap && aw && aa == 8'h00) {hd, wp} <= {hwdata[23:16], hwdata[1]};
            sd  <= sclk;
            // cycles since select rose, since it fell, since the last clock fall
            g   <= cs_n ? ((g == 8'hff) ? g : g + 8'h01) : 8'h00;
            c   <= cs_n ? 8'h00 : ((c == 8'hff) ? c : c + 8'h01);
            f   <= (sd && !sclk) ? 8'h01 : ((f == 8'hff) ? f : f + 8'h01);
            fst <= cs_n ? 1'b1 : (sclk ? 1'b0 : fst);
        end
    end
    a_idle_gap: assert property ($fell(cs_n) |-> int'(g) >= int'(tm[31:24]) + 1)
        else $error("select idle gap too short");
    a_done_prompt: assert property ($rose(cs_n) && mk[0] |-> irq)
        else $error("done held back at deselect");
    a_hold_turn: assert property ($fell(io2_oe_n) && g != 8'hff |-> int'(g) == int'(tm[19:16]))
        else $error("io turnaround delay wrong");
    a_oe_select: assert property (!cs_n && $past(!cs_n) |-> io2_oe_n && io3_oe_n)
        else $error("io lines driven while selected");
    a_oe_unused: assert property (!wp |-> io2_oe_n && io3_oe_n)
        else $error("io lines driven without hold function");
    a_oe_pair: assert property (io2_oe_n == io3_oe_n)
        else $error("third and fourth io lines differ");
    a_end_delay: assert property ($rose(cs_n) |-> int'(f) == int'(tm[11:8]) + 1)
        else $error("clock end to deselect delay wrong");
    a_lead_time: assert property ($rose(sclk) && fst |-> int'(c) == int'(tm[3:0]) + 1 + 2 * int'(h))
        else $error("select to first clock delay wrong");
    a_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("clock runs while deselected");
    c_select: cover property ($fell(cs_n));
    c_turn: cover property ($fell(io2_oe_n));
    c_irq: cover property ($rose(irq));
endmodule

// ===== verif/testbench.sv
// top bench: ahb-lite master tasks, spi slave model, data-port and timing sequences
// assumes the checker is bound from this file and io2/io3 pins are pulled high
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, io2_in = 1'b1, io3_in = 1'b1;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize  = 3'h0;
    logic [31:0] haddr  = 32'h0, hwdata = 32'h0, rd;
    wire         hreadyout, hresp, irq, sclk, cs_n, io0_out, io1_in, io2_out, io2_oe_n, io3_out, io3_oe_n;
    wire  [31:0] hrdata;
    int          n_fail = 0, checks = 0;
    logic [7:0]  q [$], r [$];
    always #5 hclk = ~hclk;
    spi_master_fifo_cs_timing u_spi_master_fifo_cs_timing (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .sclk(sclk), .cs_n(cs_n),
        .io0_out(io0_out), .io1_in(io1_in), .io2_in(io2_in), .io2_out(io2_out), .io2_oe_n(io2_oe_n),
        .io3_in(io3_in), .io3_out(io3_out), .io3_oe_n(io3_oe_n));
    spi_slave_model u_spi_slave_model (.sclk(sclk), .cs_n(cs_n), .mosi(io0_out), .miso(io1_in));
    task wrap_up;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task wait_rdy;
        int i;
        for (i = 0; hreadyout !== 1'b1; i++) begin
            if (i > 100) begin n_fail++; $display("[ERR] hready exp 1 got %b", hreadyout); wrap_up(); end
            @(posedge hclk);
        end
    endtask
    task xfer(input logic [7:0] a, input logic w, input logic [2:0] s, input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= w; hsize <= s;
        @(posedge hclk); wait_rdy();
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        @(posedge hclk); wait_rdy(); rd = hrdata;
    endtask
    task rd_chk(input string nm, input logic [7:0] a, input logic [2:0] s, input logic [31:0] e);
        xfer(a, 1'b0, s, 32'h0); `CHK(nm, e, rd)
    endtask
    task push(input logic [2:0] s, input logic [31:0] d, input logic ok);
        xfer(8'h20, 1'b1, s, d);
        if (ok) for (int i = 0; i < (1 << s); i++) q.push_back(d[8*i+:8]);
    endtask
    task wait_rx(input logic [15:0] n);
        int i;
        for (i = 0; i < 3000; i++) begin
            xfer(8'h14, 1'b0, 3'h2, 32'h0);
            if (rd[31:16] === n) begin xfer(8'h04, 1'b0, 3'h2, 32'h0); if (rd[8] === 1'b0) break; end
        end
        if (i == 3000) begin n_fail++; $display("[ERR] rx count exp %h got %h", n, rd[31:16]); wrap_up(); end
    endtask
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("timing reset", 8'h28, 3'h2, 32'h06060406);
        rd_chk("count reset", 8'h14, 3'h2, 32'h0);
        rd_chk("unmapped", 8'h30, 3'h2, 32'h0);
        xfer(8'h08, 1'b1, 3'h2, 32'h0);
        push(3'h0, 32'h11, 1'b1);
        push(3'h1, 32'h3322, 1'b1);
        push(3'h2, 32'h77665544, 1'b1);
        rd_chk("tx count 7", 8'h14, 3'h2, 32'h7);
        push(3'h2, 32'h8b8a8988, 1'b1);
        push(3'h2, 32'hc3c2c1c0, 1'b1);
        push(3'h2, 32'hdeadbeef, 1'b0);
        rd_chk("tx count 15", 8'h14, 3'h2, 32'hf);
        rd_chk("overflow", 8'h04, 3'h2, 32'h602);
        `CHK("irq masked", 1'b0, irq)
        `CHK("bus resp", 1'b0, hresp)
        `CHK("io lines out", 2'b11, {io2_out, io3_out})
        `CHK("io oe idle", 2'b11, {io2_oe_n, io3_oe_n})
        xfer(8'h08, 1'b1, 3'h2, 32'h7);
        push(3'h0, 32'h99, 1'b1);
        `CHK("irq", 1'b1, irq)
        push(3'h0, 32'haa, 1'b0);
        rd_chk("tx count 16", 8'h14, 3'h2, 32'h10);
        xfer(8'h04, 1'b1, 3'h2, 32'h7);
        xfer(8'h08, 1'b1, 3'h2, 32'h1);
        `CHK("irq clear", 1'b0, irq)
        xfer(8'h00, 1'b1, 3'h2, 32'h00080002);
        xfer(8'h00, 1'b1, 3'h2, 32'h00080403);
        r = {8'ha5, q};
        wait_rx(16'h4);
        rd_chk("rx half", 8'h24, 3'h1, {16'h0, r[1], r[0]});
        rd_chk("rx count", 8'h14, 3'h2, 32'h0002000c);
        rd_chk("rx under", 8'h24, 3'h2, {16'h0, r[3], r[2]});
        rd_chk("rx error", 8'h04, 3'h2, 32'h605);
        `CHK("io oe", 2'b00, {io2_oe_n, io3_oe_n})
        rd_chk("rx empty", 8'h14, 3'h2, 32'h0000000c);
        xfer(8'h04, 1'b1, 3'h2, 32'h7);
        xfer(8'h28, 1'b1, 3'h2, 32'h0a030201);
        rd_chk("timing set", 8'h28, 3'h2, 32'h0a030201);
        xfer(8'h00, 1'b1, 3'h2, 32'h00080203);
        xfer(8'h00, 1'b1, 3'h2, 32'h00080203);
        wait_rx(16'h4);
        rd_chk("rx word", 8'h24, 3'h2, {r[7], r[6], r[5], r[4]});
        `CHK("sent count", 8, u_spi_slave_model.n_got)
        for (int i = 0; i < 8; i++) `CHK("sent byte", q[i], u_spi_slave_model.got[i])
        wrap_up();
    end
endmodule
bind spi_master_fifo_cs_timing spi_timing_chk u_spi_timing_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .irq(irq),
    .sclk(sclk), .cs_n(cs_n), .io2_oe_n(io2_oe_n), .io3_oe_n(io3_oe_n));
